/* logic/supply_ctrl.sv */
/*
 * Supply supervision, reset sequencing, clock source selection.
 * Low battery control register behind an APB slave.
 * Assumes comparators, oscillator and power-on detector outside,
 * giving levels synchronous to clock.
 */
`timescale 1ns/100ps
module supply_ctrl
    import supply_ctrl_pkg::*;
#(
    parameter int unsigned STARTUP_COUNT = STARTUP_CYCLES
) (
    input  wire logic                            clock,
    input  wire logic                            nrst,
    input  wire logic                            psel,
    input  wire logic                            penable,
    input  wire supply_ctrl_pkg::apb_req_t       apbReq,
    output logic [supply_ctrl_pkg::DATA_W-1:0]   prdata,
    output logic                                 pready,
    output logic                                 pslverr,
    input  wire logic                            powerOnDetect,
    input  wire logic                            brownoutBelow,
    input  wire logic                            watchdogExpire,
    input  wire logic                            extResetN,
    input  wire logic                            lowBattBelow,
    input  wire logic                            haltMode,
    input  wire logic                            idleMode,
    input  wire logic                            progMode,
    input  wire logic                            progWrite,
    input  wire supply_ctrl_pkg::init_settings_t progImage,
    input  wire supply_ctrl_pkg::init_settings_t nvImageIn,
    output supply_ctrl_pkg::init_settings_t      nvImageOut,
    output logic                                 brownoutPowerOn,
    output logic                                 lowBattPowerOn,
    output logic [supply_ctrl_pkg::THR_W-1:0]    thresholdSelect,
    output logic                                 sourceSelect,
    output logic                                 ioRegReset,
    output logic                                 coreResetN,
    output logic                                 fetchStart,
    input  wire logic                            clockInput,
    output logic                                 oscRun,
    output logic                                 oscillatorOutput,
    output logic                                 oscillatorOutputEn,
    output logic                                 coreClockEn
);

    // ------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        SEQ_HOLD,
        SEQ_START,
        SEQ_WAIT,
        SEQ_RUN
    } seq_state_t;

    seq_state_t      state_reg;
    seq_state_t      state_next;
    init_settings_t  settings;
    reset_cause_t    sources;
    reset_cause_t    cause_reg;
    reset_cause_t    cause_next;
    logic            anySource;
    logic            lowPower;
    logic            borActive;
    logic            lbdActive;
    logic            timerDone;
    logic            seqStart;
    logic            running;

    logic [THR_W-1:0] threshold_reg;
    logic             srcSel_reg;
    logic             lowBattFlag_reg;
    logic [DATA_W-1:0] prdata_reg;
    logic [DATA_W-1:0] readMux;

    logic            setupPhase;
    logic            accessPhase;
    logic            hitLbc;
    logic            hitInit;
    logic            hitStat;
    logic            mapped;
    logic            lbcWrite;

    logic            divPhase_reg;
    logic            clkInPrev_reg;
    logic            clkInRise;
    logic            modeInternal;
    logic            modeSquare;
    logic            modeCrystal;
    logic            clockTick;
    logic            oscOut_reg;

    // ------------------------------------------------------------
    // initialization settings
    // ------------------------------------------------------------
    init_settings_store u_store (
        .clock     (clock),
        .nrst      (nrst),
        .load      (seqStart),
        .nvImageIn (nvImageIn),
        .progMode  (progMode),
        .progWrite (progWrite),
        .progImage (progImage),
        .settings  (settings)
    );

    assign nvImageOut = settings;

    // ------------------------------------------------------------
    // comparator enables
    // ------------------------------------------------------------
    // both comparators are powered down in halt and idle
    assign lowPower  = haltMode || idleMode;
    assign borActive = settings.brownoutEnable && !lowPower;
    assign lbdActive = settings.lowBatteryEnable && !lowPower;
    assign brownoutPowerOn = borActive;
    assign lowBattPowerOn  = lbdActive;

    // ------------------------------------------------------------
    // reset sources
    // ------------------------------------------------------------
    assign sources.powerOn  = powerOnDetect;
    assign sources.brownout = borActive && brownoutBelow;
    assign sources.watchdog = watchdogExpire;
    assign sources.extPin   = !extResetN;
    assign anySource = |sources;

    // ------------------------------------------------------------
    // reset sequencer
    // ------------------------------------------------------------
    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            SEQ_HOLD: begin
                // held while any source stays active
                if (!anySource) begin
                    state_next = SEQ_START;
                end
            end
            SEQ_START: begin
                state_next = anySource ? SEQ_HOLD : SEQ_WAIT;
            end
            SEQ_WAIT: begin
                if (anySource) begin
                    state_next = SEQ_HOLD;
                end else if (timerDone) begin
                    state_next = SEQ_RUN;
                end
            end
            SEQ_RUN: begin
                if (anySource) begin
                    state_next = SEQ_HOLD;
                end
            end
        endcase
    end

    assign seqStart = (state_reg == SEQ_START);
    assign running  = (state_reg == SEQ_RUN);

    always_comb begin
        cause_next = cause_reg;
        if (state_reg == SEQ_RUN && anySource) begin
            cause_next = sources;
        end else if (state_reg != SEQ_RUN) begin
            cause_next = cause_reg | sources;
        end
    end

    always_ff @(posedge clock) begin
        if (!nrst) begin
            state_reg <= SEQ_HOLD;
            cause_reg <= '0;
        end else begin
            state_reg <= state_next;
            cause_reg <= cause_next;
        end
    end

    startup_timer #(
        .CYCLES (STARTUP_COUNT)
    ) u_timer (
        .clock (clock),
        .nrst  (nrst),
        .start (seqStart),
        .abort (anySource),
        .done  (timerDone)
    );

    // ------------------------------------------------------------
    // core and I/O reset outputs
    // ------------------------------------------------------------
    // I/O registers stay cleared for the whole sequence
    assign ioRegReset = !running;
    assign coreResetN = running;

    always_ff @(posedge clock) begin
        if (!nrst) begin
            fetchStart <= 1'b0;
        end else begin
            fetchStart <= (state_reg == SEQ_WAIT)
                && (state_next == SEQ_RUN);
        end
    end

    // ------------------------------------------------------------
    // clock source selection
    // ------------------------------------------------------------
    assign modeInternal = (settings.clockMode == CM_INTERNAL);
    assign modeSquare   = (settings.clockMode == CM_SQUARE);
    assign modeCrystal  = (settings.clockMode == CM_CRYSTAL);

    // on-chip oscillator only for internal mode, stopped in halt
    assign oscRun = modeInternal && !haltMode;

    assign clkInRise = clockInput && !clkInPrev_reg;

    always_ff @(posedge clock) begin
        if (!nrst) begin
            divPhase_reg  <= 1'b0;
            clkInPrev_reg <= 1'b0;
            oscOut_reg    <= 1'b0;
        end else begin
            divPhase_reg  <= oscRun ? !divPhase_reg : 1'b0;
            clkInPrev_reg <= clockInput;
            oscOut_reg    <= modeCrystal && !clockInput;
        end
    end

    always_comb begin
        clockTick = 1'b0;
        if (modeInternal) begin
            clockTick = oscRun && divPhase_reg;
        end else if (modeSquare || modeCrystal) begin
            clockTick = clkInRise;
        end
    end

    // core clock gated until the start-up delay has run out
    assign coreClockEn = running && clockTick;

    assign oscillatorOutput   = oscOut_reg;
    assign oscillatorOutputEn = modeCrystal;

    // ------------------------------------------------------------
    // low battery control register and flag
    // ------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (!nrst) begin
            lowBattFlag_reg <= 1'b0;
        end else begin
            // level follows comparator, no event raised
            lowBattFlag_reg <= lbdActive && lowBattBelow;
        end
    end

    always_ff @(posedge clock) begin
        if (!nrst || !running) begin
            threshold_reg <= THR_RESET;
            srcSel_reg    <= SRC_RESET;
        end else if (lbcWrite) begin
            threshold_reg <= apbReq.pwdata[THR_LSB +: THR_W];
            srcSel_reg    <= apbReq.pwdata[SRC_SEL_BIT];
        end
    end

    assign thresholdSelect = threshold_reg;
    assign sourceSelect    = srcSel_reg;

    // ------------------------------------------------------------
    // APB slave
    // ------------------------------------------------------------
    assign setupPhase  = psel && !penable;
    assign accessPhase = psel && penable;
    assign hitLbc  = (apbReq.paddr == LBC_OFFSET);
    assign hitInit = (apbReq.paddr == INIT_OFFSET);
    assign hitStat = (apbReq.paddr == STAT_OFFSET);
    assign mapped  = hitLbc || hitInit || hitStat;
    assign lbcWrite = accessPhase && apbReq.pwrite && hitLbc;

    always_comb begin
        readMux = '0;
        if (hitLbc) begin
            readMux[THR_LSB +: THR_W] = threshold_reg;
            readMux[SRC_SEL_BIT]      = srcSel_reg;
            readMux[FLAG_BIT]         = lowBattFlag_reg;
            // bit 1 stays zero
        end else if (hitInit) begin
            readMux[INIT_BOR_BIT]          = settings.brownoutEnable;
            readMux[INIT_LBD_BIT]          = settings.lowBatteryEnable;
            readMux[INIT_MODE_LSB +: 2]    = settings.clockMode;
            readMux[INIT_WP_BIT]           = settings.globalWriteProtect;
            readMux[INIT_PROG_BIT]         = progMode;
        end else if (hitStat) begin
            readMux[STAT_RUN_BIT]            = running;
            readMux[STAT_CAUSE_LSB +: CAUSE_W] = cause_reg;
        end
    end

    // read data captured in the setup cycle, held for the access
    always_ff @(posedge clock) begin
        if (!nrst) begin
            prdata_reg <= '0;
        end else if (setupPhase) begin
            prdata_reg <= apbReq.pwrite ? '0 : readMux;
        end
    end

    assign prdata  = prdata_reg;
    assign pready  = 1'b1;
    assign pslverr = accessPhase && !mapped;

endmodule

/* logic/supply_ctrl_pkg.sv */
/*
 * Shared constants and types for the supply supervision block:
 * register map, field positions, timing counts and bus carriers.
 * Assumes a 10 MHz system clock and a 32-bit APB register bus.
 */
package supply_ctrl_pkg;

    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned DATA_W = 32;
    localparam logic [ADDR_W-1:0] LBC_OFFSET  = 8'h00;
    localparam logic [ADDR_W-1:0] INIT_OFFSET = 8'h04;
    localparam logic [ADDR_W-1:0] STAT_OFFSET = 8'h08;

    // low battery control fields
    localparam int unsigned LBC_W       = 8;
    localparam int unsigned FLAG_BIT    = 0;
    localparam int unsigned SRC_SEL_BIT = 2;
    localparam int unsigned THR_LSB     = 3;
    localparam int unsigned THR_W       = 5;
    localparam logic [THR_W-1:0] THR_RESET = 5'h00;
    localparam logic             SRC_RESET = 1'b0;

    // initialization status fields
    localparam int unsigned INIT_BOR_BIT  = 0;
    localparam int unsigned INIT_LBD_BIT  = 1;
    localparam int unsigned INIT_MODE_LSB = 2;
    localparam int unsigned INIT_WP_BIT   = 4;
    localparam int unsigned INIT_PROG_BIT = 5;

    // sequencer status fields
    localparam int unsigned STAT_RUN_BIT   = 0;
    localparam int unsigned STAT_CAUSE_LSB = 1;
    localparam int unsigned CAUSE_W        = 4;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int unsigned CLK_FREQ_HZ    = 10_000_000;
    localparam int unsigned OSC_STARTUP_US = 1000;
    localparam int unsigned STARTUP_CYCLES =
        OSC_STARTUP_US * (CLK_FREQ_HZ / 1_000_000);

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        CM_INTERNAL = 2'b00,
        CM_SQUARE   = 2'b01,
        CM_CRYSTAL  = 2'b10,
        CM_RESERVED = 2'b11
    } clock_mode_t;

    typedef struct packed {
        logic        globalWriteProtect;
        clock_mode_t clockMode;
        logic        lowBatteryEnable;
        logic        brownoutEnable;
    } init_settings_t;

    localparam init_settings_t INIT_DEFAULT = '{
        globalWriteProtect: 1'b0,
        clockMode:          CM_INTERNAL,
        lowBatteryEnable:   1'b0,
        brownoutEnable:     1'b0
    };

    typedef struct packed {
        logic [ADDR_W-1:0] paddr;
        logic              pwrite;
        logic [DATA_W-1:0] pwdata;
    } apb_req_t;

    // cause order: power-on, brown-out, watchdog, external pin
    typedef struct packed {
        logic extPin;
        logic watchdog;
        logic brownout;
        logic powerOn;
    } reset_cause_t;

endpackage

/* logic/startup_timer.sv */
/*
 * Oscillator start-up delay counter.
 * Assumes start is a one-cycle pulse; abort wins over start.
 */
`timescale 1ns/100ps
module startup_timer #(
    parameter int unsigned CYCLES = 10
) (
    input  wire logic clock,
    input  wire logic nrst,
    input  wire logic start,
    input  wire logic abort,
    output logic      done
);
    localparam int unsigned CNT_W = $clog2(CYCLES + 1);
    localparam logic [CNT_W-1:0] LAST = CNT_W'(CYCLES - 1);

    logic [CNT_W-1:0] count_reg;
    logic             busy_reg;
    logic             done_reg;

    always_ff @(posedge clock) begin
        if (!nrst || abort) begin
            busy_reg  <= 1'b0;
            count_reg <= '0;
            done_reg  <= 1'b0;
        end else if (start) begin
            busy_reg  <= 1'b1;
            count_reg <= '0;
            done_reg  <= 1'b0;
        end else if (busy_reg) begin
            count_reg <= count_reg + 1'b1;
            busy_reg  <= (count_reg != LAST);
            done_reg  <= (count_reg == LAST);
        end else begin
            done_reg  <= 1'b0;
        end
    end

    assign done = done_reg;
endmodule

/* logic/init_settings_store.sv */
/*
 * Working copy of the nonvolatile initialization settings.
 * Assumes the image is reloaded from storage at each reset sequence
 * and that nvImageOut is written back to storage by the outside.
 */
`timescale 1ns/100ps
module init_settings_store
    import supply_ctrl_pkg::*;
(
    input  wire logic                            clock,
    input  wire logic                            nrst,
    input  wire logic                            load,
    input  wire supply_ctrl_pkg::init_settings_t nvImageIn,
    input  wire logic                            progMode,
    input  wire logic                            progWrite,
    input  wire supply_ctrl_pkg::init_settings_t progImage,
    output supply_ctrl_pkg::init_settings_t      settings
);
    init_settings_t image_reg;
    init_settings_t image_next;
    logic           mayClear;

    // clearing and mode change need programming mode and no protect
    assign mayClear = progMode && !image_reg.globalWriteProtect;

    always_comb begin
        image_next = image_reg;
        if (progMode && progWrite) begin
            // set only in programming mode
            image_next.brownoutEnable = image_reg.brownoutEnable
                | progImage.brownoutEnable;
            image_next.lowBatteryEnable = image_reg.lowBatteryEnable
                | progImage.lowBatteryEnable;
            image_next.globalWriteProtect = image_reg.globalWriteProtect
                | progImage.globalWriteProtect;
            if (mayClear) begin
                image_next.brownoutEnable = progImage.brownoutEnable;
                image_next.lowBatteryEnable = progImage.lowBatteryEnable;
                image_next.clockMode = progImage.clockMode;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (!nrst) begin
            image_reg <= INIT_DEFAULT;
        end else if (load) begin
            image_reg <= nvImageIn;
        end else begin
            image_reg <= image_next;
        end
    end

    assign settings = image_reg;
endmodule

/* sim/supply_far_side.sv */
/*
 * Far side: low-battery comparator and external clock.
 * Assumes levels are reference level numbers, 1 to 32.
 */
`timescale 1ns/100ps
module supply_far_side
    import supply_ctrl_pkg::*;
(
    input  wire logic                            clock,
    input  wire logic                            squareOn,
    input  wire logic                            powered,
    input  wire logic                            sourceSelect,
    input  wire logic [supply_ctrl_pkg::THR_W-1:0] thresholdSelect,
    input  wire logic [5:0]                      supplyLevel,
    input  wire logic [5:0]                      pinLevel,
    output logic                                 lowBattBelow,
    output logic                                 clockInput
);
    logic [1:0] div = 2'h0;
    logic       junk = 1'b0;
    wire  [5:0] sensed = sourceSelect ? pinLevel : supplyLevel;
    wire  [5:0] refLevel = {1'b0, thresholdSelect} + 6'h01;

    always_ff @(posedge clock) begin
        div <= squareOn ? div + 2'h1 : 2'h0;
        junk <= !junk;
    end
    // clock stands still while off; period four cycles otherwise
    assign clockInput = div[1];
    // comparator unpowered gives no valid level
    assign lowBattBelow = powered ? (sensed < refLevel) : junk;
endmodule

/* sim/supply_ctrl_properties.sv */
/*
 * Port checker for supply_ctrl.
 * Assumes it is bound into supply_ctrl with the same STARTUP_COUNT.
 */
`timescale 1ns/100ps
module supply_ctrl_properties
    import supply_ctrl_pkg::*;
#(
    parameter int unsigned STARTUP_COUNT = 8
) (
    input wire logic clock, nrst, psel, penable, progMode, haltMode,
    input wire logic idleMode, brownoutBelow, lowBattBelow, fetchStart,
    input wire logic brownoutPowerOn, lowBattPowerOn, coreResetN,
    input wire logic ioRegReset, oscRun, coreClockEn, oscillatorOutputEn,
    input wire supply_ctrl_pkg::apb_req_t          apbReq,
    input wire logic [supply_ctrl_pkg::DATA_W-1:0] prdata,
    input wire supply_ctrl_pkg::init_settings_t    nvImageOut
);
    logic [15:0] lowCount;
    wire rdLbc = psel && penable && !apbReq.pwrite
                 && apbReq.paddr == LBC_OFFSET;
    wire intMode = nvImageOut.clockMode == CM_INTERNAL;

    always_ff @(posedge clock) begin
        if (!nrst || coreResetN) begin
            lowCount <= 16'h0000;
        end else begin
            lowCount <= lowCount + 16'h0001;
        end
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking @(posedge clock); endclocking
    default disable iff (!nrst);

    a_brownout_hold: assert property (brownoutBelow && brownoutPowerOn
        |=> !coreResetN && ioRegReset) else $error("brown-out not held");
    a_fetch_first: assert property ($rose(coreResetN)
        |-> fetchStart ##1 !fetchStart) else $error("no fetch pulse");
    a_fetch_only: assert property (fetchStart |-> $rose(coreResetN))
        else $error("stray fetch pulse");
    a_io_reset: assert property (ioRegReset == !coreResetN)
        else $error("io reset disagrees");
    a_startup_wait: assert property ($rose(coreResetN)
        |-> lowCount >= STARTUP_COUNT) else $error("start-up cut short");
    a_clock_gated: assert property (coreClockEn |-> coreResetN)
        else $error("core clock in reset");
    a_int_divide: assert property (coreClockEn && intMode
        |=> !coreClockEn) else $error("internal clock not halved");
    a_osc_run: assert property (oscRun == (intMode && !haltMode))
        else $error("oscillator run wrong");
    a_crystal_pin: assert property (oscillatorOutputEn
        == (nvImageOut.clockMode == CM_CRYSTAL)) else $error("pin drive");
    a_bor_power: assert property (brownoutPowerOn
        == (nvImageOut.brownoutEnable && !haltMode && !idleMode))
        else $error("brown-out power wrong");
    a_lbd_power: assert property (lowBattPowerOn
        == (nvImageOut.lowBatteryEnable && !haltMode && !idleMode))
        else $error("low battery power wrong");
    a_sw_locked: assert property (coreResetN && !progMode
        |=> $stable(nvImageOut)) else $error("settings changed");
    a_bit_one: assert property (rdLbc |-> !prdata[1])
        else $error("bit one set");
    a_flag_track: assert property (rdLbc && coreResetN
        && $past(coreResetN, 3) && $past(lowBattPowerOn)
        && $past(lowBattPowerOn, 2) |-> prdata[0] == $past(lowBattBelow, 2))
        else $error("flag wrong");

    c_run: cover property ($rose(coreResetN));
    c_bor: cover property (brownoutBelow && brownoutPowerOn);
    c_flag: cover property (rdLbc && prdata[0]);
endmodule

bind supply_ctrl supply_ctrl_properties #(.STARTUP_COUNT(STARTUP_COUNT))
    prop_inst (.*);

/* sim/supply_ctrl_bench.sv */
/*
 * Testbench for supply_ctrl over APB.
 * Assumes the far-side model and the bound checker.
 */
`timescale 1ns/100ps
module supply_ctrl_bench;
    import supply_ctrl_pkg::*;
    localparam int ST = 8;
    logic clock, nrst, psel, penable, pready, pslverr, powerOnDetect;
    logic brownoutBelow, watchdogExpire, extResetN, lowBattBelow, haltMode;
    logic idleMode, progMode, progWrite, brownoutPowerOn, lowBattPowerOn;
    logic sourceSelect, ioRegReset, coreResetN, fetchStart, clockInput;
    logic oscRun, oscillatorOutput, oscillatorOutputEn, coreClockEn;
    logic squareOn, lastErr;
    logic [5:0] supplyLevel, pinLevel;
    logic [THR_W-1:0] thresholdSelect;
    logic [DATA_W-1:0] prdata, rdv;
    apb_req_t apbReq;
    init_settings_t progImage, nvImageIn, nvImageOut;
    int miscompares = 0, total_checks = 0, cycles = 0, n, cnt;

    supply_ctrl #(.STARTUP_COUNT(ST)) supply_ctrl_inst (.*);
    supply_far_side supply_far_side_inst (.clock(clock),
        .squareOn(squareOn), .powered(lowBattPowerOn),
        .sourceSelect(sourceSelect), .thresholdSelect(thresholdSelect),
        .supplyLevel(supplyLevel), .pinLevel(pinLevel),
        .lowBattBelow(lowBattBelow), .clockInput(clockInput));

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    initial begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end
    always @(posedge clock) begin
        cycles++;
        if (cycles == 6000) begin
            miscompares++;
            wrap_up();
        end
    end
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] wd, output logic [31:0] rd);
        @(posedge clock);
        psel <= 1'b1;
        penable <= 1'b0;
        apbReq <= '{paddr: a, pwrite: wr, pwdata: wd};
        @(posedge clock);
        penable <= 1'b1;
        do @(posedge clock); while (pready !== 1'b1);
        rd = prdata;
        lastErr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(negedge clock);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d, rdv);
    endtask
    task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0, rdv);
        chk(rdv, exp);
    endtask
    task automatic wait_run();
        n = 0;
        @(negedge clock);
        while (coreResetN !== 1'b1 && n < 200) begin
            @(negedge clock);
            n++;
        end
        chk(32'(n >= ST && n < 200), 32'h1);
        chk(32'(fetchStart), 32'h1);
    endtask
    task automatic pulse_src(input int k, input logic [4:0] img);
        @(posedge clock);
        nvImageIn <= init_settings_t'(img);
        powerOnDetect <= (k == 0);
        brownoutBelow <= (k == 1);
        watchdogExpire <= (k == 2);
        extResetN <= (k != 3);
        repeat (3) @(posedge clock);
        powerOnDetect <= 1'b0;
        brownoutBelow <= 1'b0;
        watchdogExpire <= 1'b0;
        extResetN <= 1'b1;
        @(negedge clock);
        chk(32'(ioRegReset), 32'h1);
    endtask
    task automatic prog(input logic pm, input logic [4:0] img);
        @(posedge clock);
        progMode <= pm;
        progImage <= init_settings_t'(img);
        progWrite <= 1'b1;
        @(posedge clock);
        progWrite <= 1'b0;
        progMode <= 1'b0;
        @(negedge clock);
    endtask
    task automatic levels(input logic [5:0] s, input logic [5:0] p);
        @(posedge clock);
        supplyLevel <= s;
        pinLevel <= p;
        repeat (3) @(posedge clock);
    endtask

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    initial begin
        {nrst, psel, penable, powerOnDetect, brownoutBelow} = '0;
        {watchdogExpire, haltMode, idleMode, progMode, progWrite} = '0;
        {extResetN, squareOn, lastErr} = 3'h4;
        {apbReq, progImage, nvImageIn} = '0;
        supplyLevel = 6'h28;
        pinLevel = 6'h28;
        repeat (4) @(posedge clock);
        nrst <= 1'b1;
        wait_run();
        chk(32'(ioRegReset), 32'h0);
        rchk(INIT_OFFSET, 32'h0);
        rchk(LBC_OFFSET, 32'h0);
        wr(LBC_OFFSET, 32'hFF);
        rchk(LBC_OFFSET, 32'hFC);
        chk(32'(sourceSelect), 32'h1);
        for (int i = 0; i < 32; i++) begin
            wr(LBC_OFFSET, 32'(i) << 3);
            chk(32'(thresholdSelect), 32'(i));
        end
        prog(1'b1, 5'h03);
        chk(32'(nvImageOut), 32'h3);
        wr(LBC_OFFSET, 32'h48);
        levels(6'h05, 6'h28);
        rchk(LBC_OFFSET, 32'h49);
        chk(32'(coreResetN), 32'h1);
        wr(LBC_OFFSET, 32'h48);
        rchk(LBC_OFFSET, 32'h49);
        levels(6'h14, 6'h03);
        wr(LBC_OFFSET, 32'h4C);
        rchk(LBC_OFFSET, 32'h4D);
        wr(LBC_OFFSET, 32'h48);
        rchk(LBC_OFFSET, 32'h48);
        @(posedge clock);
        haltMode <= 1'b1;
        @(negedge clock);
        chk(32'(oscRun), 32'h0);
        chk(32'(lowBattPowerOn), 32'h0);
        @(posedge clock);
        haltMode <= 1'b0;
        repeat (100) @(posedge clock); // settle after halt
        pulse_src(1, 5'h03);
        wait_run();
        rchk(LBC_OFFSET, 32'h0);
        prog(1'b1, 5'h00);
        chk(32'(nvImageOut), 32'h0);
        prog(1'b0, 5'h03);
        chk(32'(nvImageOut), 32'h0);
        prog(1'b1, 5'h13);
        prog(1'b1, 5'h00);
        chk(32'(nvImageOut), 32'h13);
        @(posedge clock);
        squareOn <= 1'b1;
        for (int k = 0; k < 4; k++) begin
            pulse_src(k, {1'b0, 2'(k), 2'b01});
            wait_run();
            cnt = 0;
            repeat (40) begin
                @(negedge clock);
                cnt += int'(coreClockEn);
            end
            chk(32'(cnt), k == 0 ? 32'h14 : k == 3 ? 32'h0 : 32'hA);
            chk(32'(oscillatorOutputEn), 32'(k == 2));
            chk(32'(oscRun), 32'(k == 0));
        end
        apb(1'b0, 8'h0C, 32'h0, rdv);
        chk({rdv[30:0], lastErr}, 32'h1);
        wrap_up();
    end
endmodule
